// ---- rtl/tdc_sequencer.sv ----
// Two-channel transfer sequencer with APB register access.
`timescale 1ns/100ps

module tdc_sequencer (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ch0_request_n,
  input  wire logic        ch1_request_n,
  input  wire logic        bus_request_n,
  input  wire logic        nmi_n,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic      [19:0] addr_out,
  output logic             memory_strobe_n,
  output logic             io_strobe_n,
  output logic             read_n,
  output logic             write_n,
  output logic             bus_own,
  output logic             cpu_stall,
  output logic             bus_grant_n,
  output logic             ch0_transfer_end_n,
  output logic             ch1_transfer_end_n,
  output logic             transfer_irq
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [3:0] in_raw;
  logic [3:0] in_meta;
  logic [3:0] in_sync;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n  = rst_sync[1];
  assign in_raw = {nmi_n, bus_request_n, ch1_request_n, ch0_request_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          in_meta[gi] <= 1'b1;
          in_sync[gi] <= 1'b1;
        end else begin
          in_meta[gi] <= in_raw[gi];
          in_sync[gi] <= in_meta[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  tdc_pkg::tdc_ctl_type  s;
  tdc_pkg::tdc_ctl_type  next_s;
  tdc_pkg::tdc_addr_type a;
  tdc_pkg::tdc_addr_type next_a;

  logic [1:0]  req_low;
  logic [1:0]  req_fall;
  logic        ext_req;
  logic        nmi_fall;
  logic        ch0_memmem;
  logic        ch0_io_src;
  logic        ch0_io_dst;
  logic        ch1_to_mem;
  logic [1:0]  run;
  logic [1:0]  want;
  logic        rd_io;
  logic        wr_io;
  logic        acc_io;
  logic        busy;
  logic        wr_done;
  logic        rd_done;
  logic        is_last;
  logic        apb_wr;
  logic [9:0]  idx;
  logic        mapped;
  logic [31:0] rd_val;

  assign req_low    = ~in_sync[1:0];
  assign req_fall   = s.req_prev & ~in_sync[1:0];
  assign ext_req    = ~in_sync[2];
  assign nmi_fall   = s.nmi_prev & ~in_sync[3];
  assign ch0_memmem = !s.ch0_source_mode[1] && !s.ch0_dest_mode[1];
  assign ch0_io_src = s.ch0_source_mode == tdc_pkg::MODE_IO;
  assign ch0_io_dst = s.ch0_dest_mode == tdc_pkg::MODE_IO;
  assign ch1_to_mem = s.ch1_mode[1];
  assign run        = s.ch_enable & {2{s.main_transfer_enable}};
  assign want[0]    = run[0] && (ch0_memmem
                    || (s.request_sense[0] ? s.edge_pend[0] : req_low[0]));
  assign want[1]    = run[1] && (s.request_sense[1] ? s.edge_pend[1] : req_low[1]);
  assign rd_io      = s.ch ? ch1_to_mem : ch0_io_src;
  assign wr_io      = s.ch ? !ch1_to_mem : ch0_io_dst;
  assign acc_io     = (s.state == tdc_pkg::TDC_READ) ? rd_io : wr_io;
  assign busy       = s.state == tdc_pkg::TDC_READ || s.state == tdc_pkg::TDC_WRITE;
  assign rd_done    = s.state == tdc_pkg::TDC_READ && s.wcnt == tdc_pkg::WAIT_NONE;
  assign wr_done    = s.state == tdc_pkg::TDC_WRITE && s.wcnt == tdc_pkg::WAIT_NONE;
  assign is_last    = (s.ch ? a.ch1_byte_counter : a.ch0_byte_counter) == tdc_pkg::COUNT_LAST;
  assign apb_wr     = psel && penable && pwrite;
  assign idx        = paddr[11:2];

  function automatic logic [19:0] step_addr(input logic [19:0] ad, input logic [1:0] md);
    if (md == tdc_pkg::MODE_INC) begin
      step_addr = ad + 20'h00001;
    end else if (md == tdc_pkg::MODE_DEC) begin
      step_addr = ad - 20'h00001;
    end else begin
      step_addr = ad;
    end
  endfunction : step_addr

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0;
    if (idx == tdc_pkg::IDX_IO_CONTROL_B) begin
      rd_val[tdc_pkg::IOB_CH0_TRANSFER_END_N_EN] = s.ch0_transfer_end_n_enable;
    end else if (idx == tdc_pkg::IDX_CH0_SRC_ADDR) begin
      rd_val[19:0] = a.ch0_source_address;
    end else if (idx == tdc_pkg::IDX_CH0_DST_ADDR) begin
      rd_val[19:0] = a.ch0_destination_address;
    end else if (idx == tdc_pkg::IDX_CH0_COUNT) begin
      rd_val[15:0] = a.ch0_byte_counter;
    end else if (idx == tdc_pkg::IDX_CH1_MEM_ADDR) begin
      rd_val[19:0] = a.ch1_memory_address;
    end else if (idx == tdc_pkg::IDX_CH1_IO_ADDR) begin
      rd_val[15:0] = a.ch1_io_address;
    end else if (idx == tdc_pkg::IDX_CH1_COUNT) begin
      rd_val[15:0] = a.ch1_byte_counter;
    end else if (idx == tdc_pkg::IDX_STATUS_CTRL) begin
      rd_val[7:0] = {s.ch_enable[1], s.ch_enable[0], 2'h3,
                     s.ch_irq_enable[1], s.ch_irq_enable[0], 1'b0, s.main_transfer_enable};
    end else if (idx == tdc_pkg::IDX_CH0_MODE) begin
      rd_val[7:0] = {2'h0, s.ch0_dest_mode, s.ch0_source_mode, s.bus_mode_bit, 1'b0};
    end else if (idx == tdc_pkg::IDX_WAIT_REQ_CTRL) begin
      rd_val[7:0] = {s.mem_wait, s.io_wait, s.request_sense[1], s.request_sense[0],
                     s.ch1_mode};
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_a           = a;
    next_s.req_prev  = in_sync[1:0];
    next_s.nmi_prev  = in_sync[3];
    next_s.edge_pend = s.edge_pend | req_fall;
    if (psel && !penable) begin
      next_s.prdata = rd_val;
    end
    case (s.state)
      tdc_pkg::TDC_IDLE: begin
        if (!ext_req) begin
          if (want[0] && !s.pend_wr[1]) begin
            next_s.ch           = 1'b0;
            next_s.edge_pend[0] = req_fall[0];
            next_s.state        = s.pend_wr[0] ? tdc_pkg::TDC_WRITE : tdc_pkg::TDC_READ;
            next_s.wcnt         = (s.pend_wr[0] ? ch0_io_dst : ch0_io_src)
                                ? s.io_wait : tdc_pkg::WAIT_NONE;
          end else if (want[1] && !s.pend_wr[0]) begin
            next_s.ch           = 1'b1;
            next_s.edge_pend[1] = req_fall[1];
            next_s.state        = s.pend_wr[1] ? tdc_pkg::TDC_WRITE : tdc_pkg::TDC_READ;
            next_s.wcnt         = (s.pend_wr[1] ? !ch1_to_mem : ch1_to_mem)
                                ? s.io_wait : tdc_pkg::WAIT_NONE;
          end
        end
      end
      tdc_pkg::TDC_READ: begin
        if (s.wcnt != tdc_pkg::WAIT_NONE) begin
          next_s.wcnt = s.wcnt - 2'h1;
        end else begin
          next_s.data_buf      = data_in;
          next_s.pend_wr[s.ch] = 1'b1;
          if (ext_req) begin
            next_s.state = tdc_pkg::TDC_HELD;
          end else if (!run[s.ch]) begin
            next_s.state = tdc_pkg::TDC_IDLE;
          end else begin
            next_s.state = tdc_pkg::TDC_WRITE;
            next_s.wcnt  = wr_io ? s.io_wait : tdc_pkg::WAIT_NONE;
          end
        end
      end
      tdc_pkg::TDC_WRITE: begin
        if (s.wcnt != tdc_pkg::WAIT_NONE) begin
          next_s.wcnt = s.wcnt - 2'h1;
        end else begin
          next_s.pend_wr[s.ch] = 1'b0;
          if (s.ch) begin
            next_a.ch1_byte_counter   = a.ch1_byte_counter - 16'h0001;
            next_a.ch1_memory_address = step_addr(a.ch1_memory_address,
                                                  {1'b0, s.ch1_mode[0]});
          end else begin
            next_a.ch0_byte_counter        = a.ch0_byte_counter - 16'h0001;
            next_a.ch0_source_address      = step_addr(a.ch0_source_address,
                                                       s.ch0_source_mode);
            next_a.ch0_destination_address = step_addr(a.ch0_destination_address,
                                                       s.ch0_dest_mode);
          end
          if (is_last) begin
            next_s.ch_enable[s.ch] = 1'b0;
            next_s.state           = tdc_pkg::TDC_IDLE;
          end else if (ext_req) begin
            next_s.state = tdc_pkg::TDC_HELD;
          end else if (!run[s.ch]) begin
            next_s.state = tdc_pkg::TDC_IDLE;
          end else if (!s.ch && ch0_memmem) begin
            next_s.state = s.bus_mode_bit ? tdc_pkg::TDC_READ
                                          : tdc_pkg::TDC_STEAL;
          end else if (!s.request_sense[s.ch]) begin
            next_s.state = req_low[s.ch] ? tdc_pkg::TDC_READ
                                         : tdc_pkg::TDC_IDLE;
          end else if (s.edge_pend[s.ch] || req_fall[s.ch]) begin
            next_s.edge_pend[s.ch] = s.edge_pend[s.ch] && req_fall[s.ch];
            next_s.state           = tdc_pkg::TDC_READ;
          end else begin
            next_s.state = tdc_pkg::TDC_IDLE;
          end
          if (next_s.state == tdc_pkg::TDC_READ) begin
            next_s.wcnt = rd_io ? s.io_wait : tdc_pkg::WAIT_NONE;
          end
        end
      end
      tdc_pkg::TDC_STEAL: begin
        next_s.state = tdc_pkg::TDC_IDLE;
      end
      tdc_pkg::TDC_HELD: begin
        if (!ext_req) begin
          next_s.state = tdc_pkg::TDC_IDLE;
        end
      end
      default: begin
        next_s.state = tdc_pkg::TDC_IDLE;
      end
    endcase
    if (nmi_fall) begin
      next_s.main_transfer_enable = 1'b0;
    end
    if (apb_wr) begin
      if (idx == tdc_pkg::IDX_IO_CONTROL_B) begin
        next_s.ch0_transfer_end_n_enable = pwdata[tdc_pkg::IOB_CH0_TRANSFER_END_N_EN];
      end else if (idx == tdc_pkg::IDX_CH0_SRC_ADDR) begin
        next_a.ch0_source_address = pwdata[19:0];
      end else if (idx == tdc_pkg::IDX_CH0_DST_ADDR) begin
        next_a.ch0_destination_address = pwdata[19:0];
      end else if (idx == tdc_pkg::IDX_CH0_COUNT) begin
        next_a.ch0_byte_counter = pwdata[15:0];
      end else if (idx == tdc_pkg::IDX_CH1_MEM_ADDR) begin
        next_a.ch1_memory_address = pwdata[19:0];
      end else if (idx == tdc_pkg::IDX_CH1_IO_ADDR) begin
        next_a.ch1_io_address = pwdata[15:0];
      end else if (idx == tdc_pkg::IDX_CH1_COUNT) begin
        next_a.ch1_byte_counter = pwdata[15:0];
      end else if (idx == tdc_pkg::IDX_STATUS_CTRL) begin
        if (!pwdata[tdc_pkg::ST_CH0_GATE_N]) begin
          next_s.ch_enable[0] = pwdata[tdc_pkg::ST_CH0_ENABLE];
          if (pwdata[tdc_pkg::ST_CH0_ENABLE]) begin
            next_s.main_transfer_enable = 1'b1;
          end
        end
        if (!pwdata[tdc_pkg::ST_CH1_GATE_N]) begin
          next_s.ch_enable[1] = pwdata[tdc_pkg::ST_CH1_ENABLE];
          if (pwdata[tdc_pkg::ST_CH1_ENABLE]) begin
            next_s.main_transfer_enable = 1'b1;
          end
        end
        next_s.ch_irq_enable = {pwdata[tdc_pkg::ST_CH1_IRQ_EN], pwdata[tdc_pkg::ST_CH0_IRQ_EN]};
      end else if (idx == tdc_pkg::IDX_CH0_MODE) begin
        next_s.ch0_dest_mode   = pwdata[tdc_pkg::MD_DEST_LSB +: 2];
        next_s.ch0_source_mode = pwdata[tdc_pkg::MD_SRC_LSB +: 2];
        next_s.bus_mode_bit    = pwdata[tdc_pkg::MD_BUS_MODE];
      end else if (idx == tdc_pkg::IDX_WAIT_REQ_CTRL) begin
        next_s.mem_wait         = pwdata[tdc_pkg::WR_MEM_WAIT +: 2];
        next_s.io_wait          = pwdata[tdc_pkg::WR_IO_WAIT +: 2];
        next_s.request_sense[0] = pwdata[tdc_pkg::WR_SENSE_CH0];
        next_s.request_sense[1] = pwdata[tdc_pkg::WR_SENSE_CH1];
        next_s.ch1_mode         = pwdata[tdc_pkg::WR_CH1_MODE +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s         <= '0;
      s.io_wait <= tdc_pkg::IO_WAIT_RESET;
      s.req_prev <= 2'h3;
      s.nmi_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    a <= next_a;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    addr_out = 20'h0;
    if (s.state == tdc_pkg::TDC_READ) begin
      addr_out = s.ch ? (ch1_to_mem ? {4'h0, a.ch1_io_address} : a.ch1_memory_address)
                      : a.ch0_source_address;
    end else if (s.state == tdc_pkg::TDC_WRITE) begin
      addr_out = s.ch ? (ch1_to_mem ? a.ch1_memory_address : {4'h0, a.ch1_io_address})
                      : a.ch0_destination_address;
    end
  end

  assign prdata             = s.prdata;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && !mapped;
  assign data_out           = s.data_buf;
  assign memory_strobe_n    = !(busy && !acc_io);
  assign io_strobe_n        = !(busy && acc_io);
  assign read_n             = s.state != tdc_pkg::TDC_READ;
  assign write_n            = s.state != tdc_pkg::TDC_WRITE;
  assign bus_own            = busy;
  assign cpu_stall          = busy && !s.ch && ch0_memmem && s.bus_mode_bit;
  assign bus_grant_n        = s.state != tdc_pkg::TDC_HELD;
  assign ch0_transfer_end_n = !(s.state == tdc_pkg::TDC_WRITE && !s.ch && is_last
                                && s.ch0_transfer_end_n_enable);
  assign ch1_transfer_end_n = !(s.state == tdc_pkg::TDC_WRITE && s.ch && is_last);
  assign transfer_irq       = |(~s.ch_enable & s.ch_irq_enable);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_BURST_STALL: assert property (busy && !s.ch && ch0_memmem && s.bus_mode_bit
    |-> cpu_stall) else $error("Burst copy does not stall the processor.");
  AST_STEAL_GAP: assert property (wr_done && !s.ch && ch0_memmem && !s.bus_mode_bit
    && !is_last && !ext_req && run[0] |=> bus_own == 1'b0 ##1 s.state == tdc_pkg::TDC_IDLE)
    else $error("Cycle steal gave no processor cycle.");
  AST_IO_WAIT: assert property ($fell(io_strobe_n) && s.io_wait == 2'h3
    |-> !io_strobe_n [*4]) else $error("I/O access shorter than its wait setting.");
  AST_MEMMEM_START: assert property (s.state == tdc_pkg::TDC_IDLE && run[0] && ch0_memmem
    && !ext_req && !s.pend_wr[1] |=> !read_n || !write_n)
    else $error("Memory copy did not start.");
  AST_LEVEL_RELEASE: assert property (wr_done && s.ch && !s.request_sense[1] && !is_last
    && !req_low[1] && !ext_req && run[1] |=> s.state == tdc_pkg::TDC_IDLE)
    else $error("Bus kept after level request withdrawn.");
  AST_TEND_WRITE: assert property (!ch1_transfer_end_n |-> !write_n && $past(!read_n, 1)
    || !write_n) else $error("Transfer end outside write cycle.");
  AST_STROBE_EXCL: assert property (!(memory_strobe_n == 1'b0 && io_strobe_n == 1'b0))
    else $error("Both strobes active.");
  AST_PRIORITY: assert property (s.state == tdc_pkg::TDC_IDLE && want == 2'h3 && !ext_req
    && s.pend_wr == 2'h0 |=> s.ch == 1'b0) else $error("Channel 1 won over channel 0.");
  AST_HELD_QUIET: assert property (!bus_grant_n |-> memory_strobe_n && io_strobe_n)
    else $error("Strobe active while bus yielded.");
  AST_DONE_CLEAR: assert property (wr_done && is_last && s.ch_irq_enable[s.ch]
    && !apb_wr |=> transfer_irq ##1 transfer_irq) else $error("Completion interrupt missing.");
  AST_NMI_STOP: assert property (nmi_fall && !apb_wr |=> !s.main_transfer_enable ##[1:9] !busy)
    else $error("Non-maskable interrupt did not suspend.");

  COV_BURST: cover property (wr_done && s.bus_mode_bit ##1 !read_n);
  COV_HELD_MID: cover property (rd_done && ext_req ##1 !bus_grant_n);
  COV_EDGE_CONT: cover property (wr_done && s.request_sense[1] && s.ch ##1 !read_n);
  COV_LAST: cover property (!ch0_transfer_end_n);

endmodule : tdc_sequencer

// ---- rtl/tdc_pkg.sv ----
// Constants and types shared by the two-channel transfer sequencer.
package tdc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_IO_CONTROL_B  = 10'h001;
  localparam logic [9:0] IDX_CH0_SRC_ADDR  = 10'h020;
  localparam logic [9:0] IDX_CH0_DST_ADDR  = 10'h023;
  localparam logic [9:0] IDX_CH0_COUNT     = 10'h026;
  localparam logic [9:0] IDX_CH1_MEM_ADDR  = 10'h028;
  localparam logic [9:0] IDX_CH1_IO_ADDR   = 10'h02B;
  localparam logic [9:0] IDX_CH1_COUNT     = 10'h02E;
  localparam logic [9:0] IDX_STATUS_CTRL   = 10'h030;
  localparam logic [9:0] IDX_CH0_MODE      = 10'h031;
  localparam logic [9:0] IDX_WAIT_REQ_CTRL = 10'h032;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_CH1_ENABLE  = 7;
  localparam int ST_CH0_ENABLE  = 6;
  localparam int ST_CH1_GATE_N  = 5;
  localparam int ST_CH0_GATE_N  = 4;
  localparam int ST_CH1_IRQ_EN  = 3;
  localparam int ST_CH0_IRQ_EN  = 2;
  localparam int ST_MAIN_EN     = 0;
  localparam int MD_DEST_LSB    = 4;
  localparam int MD_SRC_LSB     = 2;
  localparam int MD_BUS_MODE    = 1;
  localparam int WR_MEM_WAIT    = 6;
  localparam int WR_IO_WAIT     = 4;
  localparam int WR_SENSE_CH1   = 3;
  localparam int WR_SENSE_CH0   = 2;
  localparam int WR_CH1_MODE    = 0;
  localparam int IOB_CH0_TRANSFER_END_N_EN   = 4;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0] IO_WAIT_RESET  = 2'h0;
  localparam logic [1:0] MODE_INC       = 2'h0;
  localparam logic [1:0] MODE_DEC       = 2'h1;
  localparam logic [1:0] MODE_IO        = 2'h3;
  localparam logic [1:0] WAIT_NONE      = 2'h0;
  localparam logic [15:0] COUNT_LAST    = 16'h0001;

  typedef enum logic [2:0] {
    TDC_IDLE  = 3'b000,
    TDC_READ  = 3'b001,
    TDC_WRITE = 3'b010,
    TDC_STEAL = 3'b011,
    TDC_HELD  = 3'b100
  } tdc_phase_type;

  typedef struct packed {
    tdc_phase_type state;
    logic          ch;
    logic [1:0]    wcnt;
    logic [1:0]    pend_wr;
    logic [1:0]    edge_pend;
    logic [1:0]    req_prev;
    logic          nmi_prev;
    logic [1:0]    ch_enable;
    logic [1:0]    ch_irq_enable;
    logic          main_transfer_enable;
    logic [1:0]    ch0_source_mode;
    logic [1:0]    ch0_dest_mode;
    logic          bus_mode_bit;
    logic [1:0]    mem_wait;
    logic [1:0]    io_wait;
    logic [1:0]    request_sense;
    logic [1:0]    ch1_mode;
    logic          ch0_transfer_end_n_enable;
    logic [7:0]    data_buf;
    logic [31:0]   prdata;
  } tdc_ctl_type;

  typedef struct packed {
    logic [19:0] ch0_source_address;
    logic [19:0] ch0_destination_address;
    logic [15:0] ch0_byte_counter;
    logic [19:0] ch1_memory_address;
    logic [15:0] ch1_io_address;
    logic [15:0] ch1_byte_counter;
  } tdc_addr_type;

endpackage : tdc_pkg

// ---- test/tdc_bus_model.sv ----
// Memory and I/O peripheral model on the far side of the sequencer bus.
`timescale 1ns/100ps

module tdc_bus_model (
  input  wire logic        ref_clk,
  input  wire logic        bus_own,
  input  wire logic        read_n,
  input  wire logic [19:0] addr_out,
  output logic      [7:0]  data_in
);
  logic [7:0] last = 8'h00;

  // A read returns a pattern made from the address; when idle the lines flip every cycle.
  assign data_in = (bus_own && !read_n) ? (addr_out[7:0] ^ 8'hA5) : ~last;

  always @(posedge ref_clk) begin
    last <= data_in;
  end
endmodule : tdc_bus_model

// ---- test/tb_top.sv ----
// Self-checking bench for the two-channel transfer sequencer.
`timescale 1ns/100ps

module tb_top;
  localparam logic [9:0] ST = tdc_pkg::IDX_STATUS_CTRL;
  localparam logic [9:0] WR = tdc_pkg::IDX_WAIT_REQ_CTRL;
  logic        ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, ch1_req_n = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, bus_own, read_n, write_n, ms_n, io_n, t0_n, t1_n, irq, stall;
  logic [7:0]  din, dout;
  logic [19:0] addr, m;
  logic [31:0] wq[$], eq[$];
  int          failures = 0, checked = 0;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (write_n === 1'b0) wq.push_back({stall, ms_n, io_n, t0_n & t1_n, addr, dout});

  tdc_sequencer uut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ch0_request_n(1'b1), .ch1_request_n(ch1_req_n), .bus_request_n(1'b1),
    .nmi_n(1'b1), .data_in(din), .data_out(dout), .addr_out(addr), .memory_strobe_n(ms_n),
    .io_strobe_n(io_n), .read_n, .write_n, .bus_own, .cpu_stall(stall), .bus_grant_n(),
    .ch0_transfer_end_n(t0_n), .ch1_transfer_end_n(t1_n), .transfer_irq(irq));
  tdc_bus_model bm (.ref_clk, .bus_own, .read_n, .addr_out(addr), .data_in(din));

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, d};
    @(posedge ref_clk) penable <= 1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin failures++; report_and_stop(); end
  endtask : apb

  task run(input logic [31:0] st, input logic [31:0] fin);
    int n;
    wq.delete();
    apb(1, ST, st);
    n = 0;
    while (irq !== 1'b1 && n < 500) begin @(posedge ref_clk); n++; end
    if (n >= 500) begin failures++; report_and_stop(); end
    apb(0, ST, 0);
    chk(rd, fin, "status after end");
    chk(wq.size(), eq.size(), "write count");
    foreach (eq[i]) chk(wq[i], eq[i], "write cycle");
    eq.delete();
  endtask : run

  initial begin
    void'($urandom(57557));
    repeat (10) @(posedge ref_clk);
    rst_b <= 1;
    repeat (3) @(posedge ref_clk);
    apb(0, ST, 0);
    chk(rd, 32'h30, "status reset");
    apb(0, WR, 0);
    chk(rd, 32'h0, "wait ctrl reset");
    apb(1, WR, 32'h04);
    apb(0, WR, 0);
    chk(rd, 32'h04, "sense ch0 bit");
    apb(1, WR, 32'h0);
    apb(1, ST, 32'h50);
    apb(0, ST, 0);
    chk(rd, 32'h30, "gated enable");
    apb(0, 10'h3FF, 0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    $display("test registers done");
    m = 20'($urandom) & 20'h7FFF0;
    apb(1, tdc_pkg::IDX_CH0_SRC_ADDR, {12'h0, m});
    apb(1, tdc_pkg::IDX_CH0_DST_ADDR, {12'h0, m ^ 20'h80000});
    apb(1, tdc_pkg::IDX_CH0_COUNT, 32'h3);
    apb(1, tdc_pkg::IDX_CH0_MODE, 32'h2);
    apb(1, tdc_pkg::IDX_IO_CONTROL_B, 32'h10);
    for (int i = 0; i < 3; i++)
      eq.push_back({3'b101, i != 2, 20'((m ^ 20'h80000) + i), 8'(m + i) ^ 8'hA5});
    run(32'h44, 32'h35);
    $display("test memory copy done");
    apb(1, ST, 32'h30);
    @(negedge ref_clk);
    chk(irq, 1'b0, "irq cleared");
    apb(1, tdc_pkg::IDX_CH1_MEM_ADDR, {12'h0, m});
    apb(1, tdc_pkg::IDX_CH1_IO_ADDR, 32'h55);
    apb(1, tdc_pkg::IDX_CH1_COUNT, 32'h2);
    apb(1, WR, 32'h0);
    ch1_req_n <= 0;
    for (int i = 0; i < 2; i++) eq.push_back({3'b010, i != 1, 20'h00055, 8'(m + i) ^ 8'hA5});
    run(32'h98, 32'h39);
    ch1_req_n <= 1;
    $display("test channel 1 done");
    report_and_stop();
  end
endmodule : tb_top
